// >>> verilog/darq_diag_adc_request_queue.sv
// Diagnostic ADC request queue: four slots, four-deep FIFO, converter sequencing
// How it works
// [R1] Four independent slots A-D, each requested by its own command, any order.
// [R2] Host sets up slow-settling sources before requesting their conversion.
// [R3] Ready summary ab is flag A or B; summary cd is flag C or D.
// [R4] Slot flag set when its conversion ends, cleared when host reads slot.
// [R5] Reading keeps the result; only a new result for that slot replaces it.
// [R6] Requests arriving during conversions are queued, nothing rejected or aborted.
// [R7] Queued conversions run strictly in arrival order.
// [R8] Queue holds four entries, so all four slots may be requested together.
// [R9] A repeated request for a still-waiting slot replaces its selection.
// [R10] Each result lands in the slot whose selection requested it.
// [R11] Command selection in bits 6:0; response is flag, 00, selection, value.
// [R12] Codes 03/04/05 convert selected dc sensor voltage, current, resistance.
// [R13] Code 06 converts squib loop output, code 0A the temperature sensor.
// [R14] Codes 07/08 bandgap reference and monitor; 01/02 ground, full-scale patterns.
// [R15] Codes 0B to 0E convert dc sensor channels 0 to 3 voltage.
// [R16] Codes 20 to 24 and 26 to 2B select the supply and pin monitors in order.
// [R17] Codes 2C to 2F select the two output drivers' drain and source.
// [R18] Codes 32 and 33 convert remote sensor supplies 0 and 1.
// [R19] Resistance only via slot A: current into A, voltage into B.
// [R20] Unused codes still queue and complete with flag set, value undefined.
`timescale 1ns/1ps

module darq_diag_adc_request_queue (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Decoded SPI frames and their answers
  input wire darq_pkg::darq_cmd_s cmd,
  output darq_pkg::darq_rsp_s rsp_r,
  // Global status word bits
  output logic ready_summary_ab_r,
  output logic ready_summary_cd_r,
  // Converter front end
  output logic adc_start_r,
  output darq_pkg::darq_src_e adc_source_r,
  input wire logic adc_done,
  input wire logic [9:0] adc_value,
  input wire logic [9:0] adc_value_aux
);

  // ************************************************************
  // Decoding helpers
  // ************************************************************
  function automatic logic slot_hit(input logic [7:0] addr);
    slot_hit = (addr >= darq_pkg::ADDR_SLOT_A) && (addr <= darq_pkg::ADDR_SLOT_D);
  endfunction : slot_hit

  function automatic logic [1:0] slot_of(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - darq_pkg::ADDR_SLOT_A;
    slot_of = diff[1:0];
  endfunction : slot_of

  // Unused and reserved codes map to src_none but are still converted
  function automatic darq_pkg::darq_src_e source_of(input logic [6:0] code);
    case (code)
      7'h01: source_of = darq_pkg::src_gnd_pattern; // see [R14]
      7'h02: source_of = darq_pkg::src_full_pattern; // see [R14]
      7'h03: source_of = darq_pkg::src_dc_sensor_volt_sel; // see [R12]
      7'h04: source_of = darq_pkg::src_dc_sensor_amp_sel; // see [R12]
      7'h05: source_of = darq_pkg::src_dc_sensor_res_sel; // see [R12]
      7'h06: source_of = darq_pkg::src_squib_loop; // see [R13]
      7'h07: source_of = darq_pkg::src_bandgap_ref_level; // see [R14]
      7'h08: source_of = darq_pkg::src_bandgap_monitor_level; // see [R14]
      7'h0a: source_of = darq_pkg::src_temp; // see [R13]
      7'h0b: source_of = darq_pkg::src_dcs_volt0; // see [R15]
      7'h0c: source_of = darq_pkg::src_dcs_volt1; // see [R15]
      7'h0d: source_of = darq_pkg::src_dcs_volt2; // see [R15]
      7'h0e: source_of = darq_pkg::src_dcs_volt3; // see [R15]
      7'h20: source_of = darq_pkg::src_battery_monitor_level; // see [R16]
      7'h21: source_of = darq_pkg::src_device_battery_level; // see [R16]
      7'h22: source_of = darq_pkg::src_analog_internal_supply; // see [R16]
      7'h23: source_of = darq_pkg::src_digital_internal_supply; // see [R16]
      7'h24: source_of = darq_pkg::src_boost_output_level; // see [R16]
      7'h26: source_of = darq_pkg::src_reserve_level; // see [R16]
      7'h27: source_of = darq_pkg::src_optional_supply_level; // see [R16]
      7'h28: source_of = darq_pkg::src_io_supply_level; // see [R16]
      7'h29: source_of = darq_pkg::src_wake_input_level; // see [R16]
      7'h2a: source_of = darq_pkg::src_safing_regulator_level; // see [R16]
      7'h2b: source_of = darq_pkg::src_watchdog_defeat_pin_level; // see [R16]
      7'h2c: source_of = darq_pkg::src_out_driver0_drain; // see [R17]
      7'h2d: source_of = darq_pkg::src_out_driver0_source; // see [R17]
      7'h2e: source_of = darq_pkg::src_out_driver1_drain; // see [R17]
      7'h2f: source_of = darq_pkg::src_out_driver1_source; // see [R17]
      7'h32: source_of = darq_pkg::src_remote_sensor_supply0; // see [R18]
      7'h33: source_of = darq_pkg::src_remote_sensor_supply1; // see [R18]
      default: source_of = darq_pkg::src_none; // see [R20]
    endcase
  endfunction : source_of

  // ************************************************************
  // State
  // ************************************************************
  darq_pkg::darq_slot_s slot_r [darq_pkg::SLOTS];
  darq_pkg::darq_slot_s slot_nxt [darq_pkg::SLOTS];
  logic [6:0] pend_sel_r [darq_pkg::SLOTS];
  logic [6:0] pend_sel_nxt [darq_pkg::SLOTS];
  logic [1:0] queue_r [darq_pkg::QUEUE_DEPTH];
  logic [1:0] queue_nxt [darq_pkg::QUEUE_DEPTH];
  logic [3:0] pend_r;
  logic [3:0] pend_nxt;
  logic [2:0] qcnt_r;
  logic [2:0] qcnt_nxt;
  darq_pkg::darq_state_e state_r;
  darq_pkg::darq_state_e state_nxt;
  logic [1:0] cur_slot_r;
  logic [1:0] cur_slot_nxt;
  logic [6:0] cur_sel_r;
  logic [6:0] cur_sel_nxt;
  darq_pkg::darq_rsp_s rsp_nxt;
  logic ready_ab_nxt;
  logic ready_cd_nxt;
  logic adc_start_nxt;
  darq_pkg::darq_src_e adc_source_nxt;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    logic [1:0] s;
    logic hit;
    s = slot_of(cmd.addr);
    hit = cmd.valid && slot_hit(cmd.addr); // see [R1]
    slot_nxt = slot_r;
    pend_sel_nxt = pend_sel_r;
    queue_nxt = queue_r;
    pend_nxt = pend_r;
    qcnt_nxt = qcnt_r;
    state_nxt = state_r;
    cur_slot_nxt = cur_slot_r;
    cur_sel_nxt = cur_sel_r;
    adc_start_nxt = 1'b0;
    adc_source_nxt = adc_source_r;
    rsp_nxt = '0;

    // Every slot frame returns the stored result; flag drops, value stays
    if (hit) begin
      rsp_nxt.valid = 1'b1;
      rsp_nxt.data = {slot_r[s].fresh, 2'b00, slot_r[s].sel, slot_r[s].value}; // see [R11]
      slot_nxt[s].fresh = 1'b0; // see [R4] see [R5]
    end

    // Pop the oldest request when the converter is free
    if (state_r == darq_pkg::st_idle && qcnt_r != darq_pkg::QCNT_RESET) begin
      cur_slot_nxt = queue_r[0];
      cur_sel_nxt = pend_sel_r[queue_r[0]];
      adc_source_nxt = source_of(pend_sel_r[queue_r[0]]);
      adc_start_nxt = 1'b1;
      pend_nxt[queue_r[0]] = 1'b0;
      for (int i = 0; i < darq_pkg::QUEUE_DEPTH - 1; i++) begin
        queue_nxt[i] = queue_r[i + 1]; // see [R7]
      end
      qcnt_nxt = qcnt_r - 3'h1;
      state_nxt = darq_pkg::st_convert;
    end

    // New request: a waiting slot only has its selection replaced
    if (hit && cmd.wr) begin
      pend_sel_nxt[s] = cmd.sel; // see [R9]
      if (!pend_nxt[s]) begin
        // Each slot sits in the queue at most once, so four entries never overflow
        queue_nxt[qcnt_nxt[1:0]] = s; // see [R6] see [R8]
        pend_nxt[s] = 1'b1;
        qcnt_nxt = qcnt_nxt + 3'h1;
      end
    end

    // Result write happens after the read clear so a same-cycle completion wins
    if (state_r == darq_pkg::st_convert && adc_done) begin
      slot_nxt[cur_slot_r].value = adc_value; // see [R10] see [R5]
      slot_nxt[cur_slot_r].sel = cur_sel_r;
      slot_nxt[cur_slot_r].fresh = 1'b1; // see [R4] see [R20]
      if (cur_slot_r == darq_pkg::SLOT_A && cur_sel_r == darq_pkg::CODE_DCS_RES) begin
        slot_nxt[darq_pkg::SLOT_B].value = adc_value_aux; // see [R19]
        slot_nxt[darq_pkg::SLOT_B].sel = cur_sel_r;
        slot_nxt[darq_pkg::SLOT_B].fresh = 1'b1;
      end
      state_nxt = darq_pkg::st_idle;
    end

    case (state_r)
      darq_pkg::st_idle: begin
      end
      darq_pkg::st_convert: begin
      end
      default: begin
        state_nxt = darq_pkg::st_idle;
      end
    endcase

    ready_ab_nxt = slot_nxt[0].fresh | slot_nxt[1].fresh; // see [R3]
    ready_cd_nxt = slot_nxt[2].fresh | slot_nxt[3].fresh; // see [R3]
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < darq_pkg::SLOTS; i++) begin
        slot_r[i] <= '{fresh: 1'b0, sel: darq_pkg::SEL_RESET, value: darq_pkg::VALUE_RESET};
        pend_sel_r[i] <= darq_pkg::SEL_RESET;
        queue_r[i] <= 2'h0;
      end
      pend_r <= 4'h0;
      qcnt_r <= darq_pkg::QCNT_RESET;
      state_r <= darq_pkg::st_idle;
      cur_slot_r <= 2'h0;
      cur_sel_r <= darq_pkg::SEL_RESET;
      rsp_r <= '0;
      ready_summary_ab_r <= 1'b0;
      ready_summary_cd_r <= 1'b0;
      adc_start_r <= 1'b0;
      adc_source_r <= darq_pkg::src_none;
    end else begin
      slot_r <= slot_nxt;
      pend_sel_r <= pend_sel_nxt;
      queue_r <= queue_nxt;
      pend_r <= pend_nxt;
      qcnt_r <= qcnt_nxt;
      state_r <= state_nxt;
      cur_slot_r <= cur_slot_nxt;
      cur_sel_r <= cur_sel_nxt;
      rsp_r <= rsp_nxt;
      ready_summary_ab_r <= ready_ab_nxt;
      ready_summary_cd_r <= ready_cd_nxt;
      adc_start_r <= adc_start_nxt;
      adc_source_r <= adc_source_nxt;
    end
  end

endmodule : darq_diag_adc_request_queue

// >>> inc/darq_pkg.sv
// Package: constants, carriers and types of the diagnostic ADC request queue
package darq_pkg;

  // ************************************************************
  // Slot addresses, field layout, sizes
  // ************************************************************
  localparam logic [7:0] ADDR_SLOT_A = 8'h3a;
  localparam logic [7:0] ADDR_SLOT_D = 8'h3d;
  localparam int SLOTS = 4;
  localparam int QUEUE_DEPTH = 4;
  localparam int SEL_W = 7;
  localparam int VAL_W = 10;
  localparam int RSP_W = 20;
  localparam int FRESH_POS = 19;
  localparam logic [1:0] SLOT_A = 2'h0;
  localparam logic [1:0] SLOT_B = 2'h1;
  localparam logic [2:0] QCNT_RESET = 3'h0;
  localparam logic [9:0] VALUE_RESET = 10'h000;
  localparam logic [6:0] SEL_RESET = 7'h00;

  // ************************************************************
  // Selection codes with special handling
  // ************************************************************
  localparam logic [6:0] CODE_DCS_RES = 7'h05;

  // ************************************************************
  // Measurement sources driven to the converter front end
  // ************************************************************
  typedef enum logic [5:0] {
    src_none, src_gnd_pattern, src_full_pattern, src_dc_sensor_volt_sel,
    src_dc_sensor_amp_sel, src_dc_sensor_res_sel, src_squib_loop,
    src_bandgap_ref_level, src_bandgap_monitor_level, src_temp,
    src_dcs_volt0, src_dcs_volt1, src_dcs_volt2, src_dcs_volt3,
    src_battery_monitor_level, src_device_battery_level, src_analog_internal_supply,
    src_digital_internal_supply, src_boost_output_level, src_reserve_level,
    src_optional_supply_level, src_io_supply_level, src_wake_input_level,
    src_safing_regulator_level, src_watchdog_defeat_pin_level,
    src_out_driver0_drain, src_out_driver0_source, src_out_driver1_drain,
    src_out_driver1_source, src_remote_sensor_supply0, src_remote_sensor_supply1
  } darq_src_e;

  typedef enum {st_idle, st_convert} darq_state_e;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic wr;
    logic [7:0] addr;
    logic [6:0] sel;
  } darq_cmd_s;

  typedef struct packed {
    logic valid;
    logic [19:0] data;
  } darq_rsp_s;

  typedef struct packed {
    logic fresh;
    logic [6:0] sel;
    logic [9:0] value;
  } darq_slot_s;

endpackage : darq_pkg

// >>> tb/darq_props.sv
// Port checker for the diagnostic ADC request queue
`timescale 1ns/1ps
module darq_props (
  // Clock, reset, frames
  input wire logic clk,
  input wire logic rst,
  input wire darq_pkg::darq_cmd_s cmd,
  input wire darq_pkg::darq_rsp_s rsp_r,
  // Status and converter
  input wire logic ready_summary_ab_r,
  input wire logic ready_summary_cd_r,
  input wire logic adc_start_r,
  input wire darq_pkg::darq_src_e adc_source_r,
  input wire logic adc_done
);
  // ************************************************************
  // Properties
  // ************************************************************
  logic hit;
  logic ab_rd;
  assign hit = cmd.valid && cmd.addr >= darq_pkg::ADDR_SLOT_A && cmd.addr <= darq_pkg::ADDR_SLOT_D;
  assign ab_rd = cmd.valid && (cmd.addr - darq_pkg::ADDR_SLOT_A) < 8'h02;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_frame;
    hit;
  endsequence
  sequence s_start;
    adc_start_r ##1 !adc_start_r;
  endsequence
  a_rsp_next_cycle: assert property (s_frame |=> rsp_r.valid)
    else $error("no answer after slot frame");
  a_rsp_refused: assert property (!hit |=> !rsp_r.valid)
    else $error("answer without slot frame");
  a_rsp_zero_pad: assert property (rsp_r.valid |-> rsp_r.data[18:17] == 2'b00)
    else $error("pad bits not zero");
  a_start_one_pulse: assert property (adc_start_r |-> s_start)
    else $error("start longer than one cycle");
  a_start_after_done: assert property (adc_done |=> !adc_start_r)
    else $error("start right after done");
  a_source_holds: assert property (!adc_start_r |-> $stable(adc_source_r))
    else $error("source changed without start");
  a_ab_rise_done: assert property ($rose(ready_summary_ab_r) |-> $past(adc_done))
    else $error("ready ab rose without done");
  a_cd_rise_done: assert property ($rose(ready_summary_cd_r) |-> $past(adc_done))
    else $error("ready cd rose without done");
  a_ab_fall_read: assert property ($fell(ready_summary_ab_r) |-> $past(ab_rd))
    else $error("ready ab fell without read");
endmodule : darq_props
bind darq_diag_adc_request_queue darq_props u_props (.clk(clk), .rst(rst), .cmd(cmd),
  .rsp_r(rsp_r), .ready_summary_ab_r(ready_summary_ab_r),
  .ready_summary_cd_r(ready_summary_cd_r), .adc_start_r(adc_start_r),
  .adc_source_r(adc_source_r), .adc_done(adc_done));

// >>> tb/darq_adc_model.sv
// Converter front end model with adjustable latency
`timescale 1ns/1ps
module darq_adc_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Start and source from the block, latency from the bench
  input wire logic start,
  input wire darq_pkg::darq_src_e src,
  input wire logic [4:0] lat,
  // Answer
  output logic done,
  output logic [9:0] value,
  output logic [9:0] value_aux
);
  logic busy;
  logic [4:0] cnt;
  always @(posedge clk) begin
    if (rst) busy <= 1'b0;
    else if (start) {busy, cnt} <= {1'b1, lat};
    else if (busy && cnt != 5'h00) cnt <= cnt - 5'h01;
    else busy <= 1'b0;
  end
  assign done = busy && cnt == 5'h00;
  // Outside the done cycle the data is inverted so a stale sample shows up
  assign value = done ? {4'h5, 6'(src)} : ~{4'h5, 6'(src)};
  assign value_aux = done ? {4'ha, 6'(src)} : ~{4'ha, 6'(src)};
endmodule : darq_adc_model

// >>> tb/darq_diag_adc_request_queue_tb.sv
// Self-checking bench for the diagnostic ADC request queue
`timescale 1ns/1ps
module darq_diag_adc_request_queue_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  darq_pkg::darq_cmd_s cmd = '0;
  darq_pkg::darq_rsp_s rsp_r, r;
  darq_pkg::darq_src_e src_r;
  logic ab_r, cd_r, start_r, done;
  logic [9:0] val, aux;
  logic [4:0] lat = 5'h00;
  logic [31:0] seed = 32'd55076;
  logic [7:0] a, bad;
  int mismatches = 0;
  int samples_checked = 0;
  logic [6:0] qc [6] = '{7'h0a, 7'h20, 7'h21, 7'h0b, 7'h07, 7'h2c};
  logic [1:0] qs [6] = '{2'h0, 2'h3, 2'h2, 2'h1, 2'h0, 2'h2};
  int ord [4] = '{1, 5, 3, 4};
  logic [6:0] rc [4] = '{7'h07, 7'h0b, 7'h2c, 7'h20};
  always #5 clk = ~clk;
  darq_diag_adc_request_queue uut (.clk(clk), .rst(rst), .cmd(cmd), .rsp_r(rsp_r),
    .ready_summary_ab_r(ab_r), .ready_summary_cd_r(cd_r), .adc_start_r(start_r),
    .adc_source_r(src_r), .adc_done(done), .adc_value(val), .adc_value_aux(aux));
  darq_adc_model u_adc (.clk(clk), .rst(rst), .start(start_r), .src(src_r), .lat(lat),
    .done(done), .value(val), .value_aux(aux));
  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [5:0] src_idx(input logic [6:0] c);
    if (c >= 7'h01 && c <= 7'h08) return 6'(c);
    if (c >= 7'h0a && c <= 7'h0e) return 6'(c - 7'd1);
    if (c >= 7'h20 && c <= 7'h24) return 6'(c - 7'd18);
    if (c >= 7'h26 && c <= 7'h2f) return 6'(c - 7'd19);
    if (c == 7'h32 || c == 7'h33) return 6'(c - 7'd21);
    return 6'h00;
  endfunction : src_idx
  function automatic logic [19:0] word(input logic f, input logic [6:0] c);
    return {f, 2'b00, c, 4'h5, src_idx(c)};
  endfunction : word
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic send(input logic [7:0] ad, input logic wr, input logic [6:0] s);
    cmd = '{valid: 1'b1, wr: wr, addr: ad, sel: s};
    @(posedge clk);
    #1 r = rsp_r;
  endtask : send
  task automatic wait_start(input logic [5:0] e);
    cmd.valid = 1'b0;
    for (int n = 0; n < 100 && start_r !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("start source", {start_r, 6'(src_r)}, {1'b1, e});
    @(posedge clk);
    #1;
  endtask : wait_start
  task automatic wait_done();
    cmd.valid = 1'b0;
    for (int n = 0; n < 100 && done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
  endtask : wait_done
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    #500000;
    mismatches++;
    conclude();
  end
  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    chk("reset outputs", {rsp_r, ab_r, cd_r, start_r, 6'(src_r)}, 32'h0);
    for (int c = 0; c < 52; c++) begin
      a = darq_pkg::ADDR_SLOT_A + 8'(c[1:0]);
      lat = 5'(rnd() & 32'h7);
      send(a, 1'b1, c[6:0]);
      chk("old flag", r.data[19], 1'b0);
      wait_start(src_idx(c[6:0]));
      wait_done();
      chk("ready", {ab_r, cd_r}, c[1] ? 2'b01 : 2'b10);
      send(a, 1'b0, 7'h00);
      chk("result", {r.valid, r.data}, {1'b1, word(1'b1, c[6:0])});
      send(a, 1'b0, 7'h00);
      chk("reread", r.data, word(1'b0, c[6:0]));
      bad = 8'(rnd());
      if (bad >= 8'h3a && bad <= 8'h3d) bad ^= 8'h80;
      send(bad, 1'b1, 7'(rnd()));
      chk("refused", r.valid, 1'b0);
    end
    // Long conversions stand for sources that need settling before sampling
    lat = 5'd20 + 5'(rnd() & 32'h7);
    for (int i = 0; i < 6; i++) begin
      send(darq_pkg::ADDR_SLOT_A + 8'(qs[i]), 1'b1, qc[i]);
      if (i == 0) wait_start(src_idx(qc[0]));
    end
    for (int i = 0; i < 4; i++) begin
      wait_done();
      wait_start(src_idx(qc[ord[i]]));
    end
    wait_done();
    chk("ready both", {ab_r, cd_r}, 2'b11);
    for (int i = 0; i < 4; i++) begin
      send(darq_pkg::ADDR_SLOT_A + 8'(i), 1'b0, 7'h00);
      chk("queued result", r.data, word(1'b1, rc[i]));
    end
    lat = 5'(rnd() & 32'h7);
    send(darq_pkg::ADDR_SLOT_A, 1'b1, darq_pkg::CODE_DCS_RES);
    wait_start(6'd5);
    wait_done();
    send(darq_pkg::ADDR_SLOT_A, 1'b0, 7'h00);
    chk("res current", r.data[9:0], {4'h5, 6'd5});
    send(darq_pkg::ADDR_SLOT_A + 8'h01, 1'b0, 7'h00);
    chk("res voltage", {r.data[19], r.data[9:0]}, {1'b1, 4'ha, 6'd5});
    cmd.valid = 1'b0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    send(darq_pkg::ADDR_SLOT_A, 1'b0, 7'h00);
    chk("after reset", {r.valid, r.data, ab_r, cd_r}, {1'b1, 22'h0});
    conclude();
  end
endmodule : darq_diag_adc_request_queue_tb
